// ---- rcsb_bank.v ----
`timescale 1ns/1ns
`include "rcsb_consts.vh"
// Functional notes
// - single write: zero opens, nonzero closes
// - multi write: one item per channel group
// - close sets listed closed, open sets open
// - query returns one flag: 1 if any masked channel closed, else 0
// - slot read returns packed sixteen-bit value
// - slot read repeats requested count times, once for a count of zero
// - slot write loads whole pattern
// - bit n is channel n
// - signed and unsigned map to same bits
// - pattern lists applied in order
// - multi-slot patterns applied per slot
// - reset restores power-on state
// - power-on state is all open
// - unaddressed channels keep state
// - reads report stored state only
// - bit is 1 closed, 0 open
// - identity read returns fixed model code
module rcsb_bank #(
    parameter [15:0] IDENT_CODE = 16'h5A5A, // Arbitrary neutral identity value
    parameter [7:0] SLOT_ADDR = 8'h00
) (
    // Clock and reset
    input wire REF_CLK,
    input wire NRST,
    // Operation request, one operation per strobe
    input wire OP_VALID,
    input wire [3:0] OP_CODE,
    input wire [7:0] OP_SLOT,
    input wire [15:0] OP_MASK,
    input wire [15:0] OP_DATA,
    input wire [7:0] OP_REPEAT,
    output wire OP_READY,
    // Result stream
    output reg RES_VALID,
    output reg [15:0] RES_DATA,
    output reg RES_LAST,
    // Programmed state, for the relay drivers
    output reg [15:0] CH_STATE
);
    // One-hot sequencer states: idle takes requests, read streams repeats
    localparam ST_IDLE = 2'b01;
    localparam ST_READ = 2'b10;

    // Sequencer bookkeeping
    reg [1:0] state;
    reg [1:0] next_state;
    reg [7:0] remain;
    reg [7:0] next_remain;

    // Channel image and result staging
    reg [15:0] next_chan;
    reg next_res_valid;
    reg [15:0] next_res_data;
    reg next_res_last;

    // Request qualification and decode
    wire hit;
    wire take;
    wire is_chan_write;
    wire is_close;
    wire is_open;
    wire is_slot_write;
    wire is_reset;
    wire is_query;
    wire is_slot_read;
    wire is_ident;
    wire multi_read;

    // Reduce any item to a closed/open flag; any nonzero value closes
    function nz;
        input [15:0] v;
        begin
            nz = |v;
        end
    endfunction

    // Close the masked channels, leave the rest alone
    function [15:0] set_bits;
        input [15:0] cur;
        input [15:0] m;
        begin
            set_bits = cur | m;
        end
    endfunction

    // Open the masked channels, leave the rest alone
    function [15:0] clr_bits;
        input [15:0] cur;
        input [15:0] m;
        begin
            clr_bits = cur & ~m;
        end
    endfunction

    // Opcode match, shared by every decode below
    function is_op;
        input [3:0] code;
        input [3:0] want;
        begin
            is_op = (code == want);
        end
    endfunction

    // Only this slot's requests count; others pass with no sign
    assign hit = (OP_SLOT == SLOT_ADDR);
    // Busy while a repeated read streams out; caller must wait
    assign OP_READY = (state == ST_IDLE);
    // Refused requests never reach the decode below
    assign take = OP_VALID && OP_READY && hit;

    // Operation decode; undefined codes match nothing and are ignored
    assign is_chan_write = take && (is_op(OP_CODE, `RCSB_OP_CH_WRITE) ||
        is_op(OP_CODE, `RCSB_OP_CH_MULTI));
    assign is_close = take && is_op(OP_CODE, `RCSB_OP_CLOSE);
    assign is_open = take && is_op(OP_CODE, `RCSB_OP_OPEN);
    assign is_slot_write = take && is_op(OP_CODE, `RCSB_OP_SLOT_WRITE);
    assign is_reset = take && is_op(OP_CODE, `RCSB_OP_RESET);
    assign is_query = take && is_op(OP_CODE, `RCSB_OP_QUERY);
    assign is_slot_read = take && is_op(OP_CODE, `RCSB_OP_SLOT_READ);
    assign is_ident = take && is_op(OP_CODE, `RCSB_OP_IDENT);
    // A count of zero or one still gives a single result
    assign multi_read = (OP_REPEAT > 8'h01);

    // New channel image; one write lands whole, so a later read sees it all
    always @* begin
        next_chan = CH_STATE;
        if (is_chan_write) begin
            // Mask names the channel or range; others untouched
            if (nz(OP_DATA)) begin
                next_chan = set_bits(CH_STATE, OP_MASK);
            end else begin
                next_chan = clr_bits(CH_STATE, OP_MASK);
            end
        end else if (is_close) begin
            next_chan = set_bits(CH_STATE, OP_MASK);
        end else if (is_open) begin
            next_chan = clr_bits(CH_STATE, OP_MASK);
        end else if (is_slot_write) begin
            // Bit n drives channel n; sign is irrelevant to the bits
            next_chan = OP_DATA;
        end else if (is_reset) begin
            next_chan = `RCSB_RESET_STATE;
        end
    end

    // Result stream next values; pulses fall back low unless set again, so valid stays high while a repeat streams
    always @* begin
        next_state = state;
        next_remain = remain;
        next_res_valid = 1'b0;
        next_res_data = RES_DATA;
        next_res_last = 1'b0;
        case (state)
            ST_IDLE: begin
                if (is_query) begin
                    // One result for the whole mask: 1 if any masked channel is closed
                    next_res_valid = 1'b1;
                    next_res_data = {15'h0000, nz(CH_STATE & OP_MASK)};
                    next_res_last = 1'b1;
                end else if (is_ident) begin
                    // Fixed stand-in for the model string
                    next_res_valid = 1'b1;
                    next_res_data = IDENT_CODE;
                    next_res_last = 1'b1;
                end else if (is_slot_read) begin
                    next_res_valid = 1'b1;
                    next_res_data = CH_STATE;
                    if (multi_read) begin
                        next_remain = OP_REPEAT - 8'h01;
                        next_state = ST_READ;
                    end else begin
                        next_res_last = 1'b1;
                    end
                end
            end
            ST_READ: begin
                // Store cannot change here: no write taken while busy
                next_res_valid = 1'b1;
                next_res_data = CH_STATE;
                next_remain = remain - 8'h01;
                if (remain == 8'h01) begin
                    next_res_last = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Channel store; the relay drivers follow it directly
    always @(posedge REF_CLK) begin
        if (!NRST) begin
            CH_STATE <= `RCSB_RESET_STATE;
        end else begin
            CH_STATE <= next_chan;
        end
    end

    // Sequencer registers
    always @(posedge REF_CLK) begin
        if (!NRST) begin
            state <= ST_IDLE;
            remain <= 8'h00;
        end else begin
            state <= next_state;
            remain <= next_remain;
        end
    end

    // Result registers; a result stands for one cycle only
    always @(posedge REF_CLK) begin
        if (!NRST) begin
            RES_VALID <= 1'b0;
            RES_DATA <= 16'h0000;
            RES_LAST <= 1'b0;
        end else begin
            RES_VALID <= next_res_valid;
            RES_DATA <= next_res_data;
            RES_LAST <= next_res_last;
        end
    end
endmodule

// ---- rcsb_consts.vh ----
`ifndef RCSB_CONSTS_VH
`define RCSB_CONSTS_VH
// Operation codes on OP_CODE
`define RCSB_OP_NONE 4'h0
`define RCSB_OP_CH_WRITE 4'h1
`define RCSB_OP_CH_MULTI 4'h2
`define RCSB_OP_CLOSE 4'h3
`define RCSB_OP_OPEN 4'h4
`define RCSB_OP_SLOT_WRITE 4'h5
`define RCSB_OP_RESET 4'h6
`define RCSB_OP_QUERY 4'h7
`define RCSB_OP_SLOT_READ 4'h8
`define RCSB_OP_IDENT 4'h9
// Power-on pattern: every channel open
`define RCSB_RESET_STATE 16'h0000
// Longest literal list
`define RCSB_LIST_MAX 4'hA
`endif

// ---- rcsb_props.sv ----
`timescale 1ns/1ns
module rcsb_props #(parameter [7:0] S=0) (
  input wire REF_CLK, NRST, OP_VALID, OP_READY, RES_VALID, RES_LAST,
  input wire [3:0] OP_CODE,
  input wire [7:0] OP_SLOT, OP_REPEAT,
  input wire [15:0] OP_MASK, OP_DATA, RES_DATA, CH_STATE);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  // Code taken by this slot, else none
  wire [3:0] c = OP_VALID&&OP_READY&&OP_SLOT==S ? OP_CODE : 4'h0;
  wire [15:0] s = CH_STATE, m = OP_MASK, d = OP_DATA;
  AST_ONE: assert property(c==1 |=> s==$past(d?s|m:s&~m)) else $error("one");
  AST_MUL: assert property(c==2 |=> s==$past(d?s|m:s&~m)) else $error("mul");
  AST_CLS: assert property(c==3 |=> s==$past(s|m)) else $error("cls");
  AST_OPN: assert property(c==4 |=> s==$past(s&~m)) else $error("opn");
  AST_LD: assert property(c==5 |=> s==$past(d)) else $error("ld");
  AST_QRY: assert property(c==7 |=> RES_VALID&&RES_DATA==$past(|(s&m))) else $error("q");
  AST_RD: assert property(c==8 |=> RES_VALID&&RES_DATA==$past(s)) else $error("rd");
  AST_RPT: assert property(c==8&&OP_REPEAT==3 |=> !RES_LAST[*2] ##1 RES_LAST) else $error("n");
  cover property(c==5);
  cover property(c==7);
  cover property(c==8&&OP_REPEAT==3);
endmodule

// ---- rcsb_host.sv ----
`timescale 1ns/1ns
// One request per list item, data scrambled once released
module rcsb_host (input wire REF_CLK, output reg OP_VALID=0, output reg [3:0] OP_CODE=0,
  output reg [7:0] OP_SLOT=0, OP_REPEAT=0, output reg [15:0] OP_MASK=0, OP_DATA=0);
  task op(input [3:0] c, input [15:0] m, d, input [7:0] r, s);
    @(posedge REF_CLK) {OP_VALID,OP_CODE,OP_SLOT,OP_MASK,OP_DATA,OP_REPEAT}<={1'b1,c,s,m,d,r};
    @(posedge REF_CLK) {OP_VALID,OP_DATA}<={1'b0,~d};
  endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ns
module testbench;
  reg REF_CLK=0, NRST=0;
  wire OP_VALID, OP_READY, RES_VALID, RES_LAST;
  wire [3:0] OP_CODE;
  wire [7:0] OP_SLOT, OP_REPEAT;
  wire [15:0] OP_MASK, OP_DATA, RES_DATA, CH_STATE;
  int n_mismatch=0, samples_checked=0;
  always #5 REF_CLK=~REF_CLK;
  rcsb_bank #(.IDENT_CODE(16'h3C3C), .SLOT_ADDR(8'h04)) u_dut (.*); // Arbitrary id
  rcsb_host u_cmd (.*);
  task results;
    $display("checked %0d wrong %0d", samples_checked, n_mismatch);
    if (n_mismatch==0 && samples_checked>0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Result one cycle on, bit 16 the last flag
  task get(input [16:0] e);
    @(negedge REF_CLK);
    samples_checked++;
    if ({RES_VALID,RES_LAST,RES_DATA}!=={1'b1,e}) begin
      n_mismatch++;
      $display("wrong value at %0t: %h", $time, RES_DATA);
    end
  endtask
  // Ready in bit 16, programmed state below
  task st(input [16:0] e);
    samples_checked++;
    if ({OP_READY,CH_STATE}!==e) begin
      n_mismatch++;
      $display("wrong value at %0t: state %h", $time, CH_STATE);
    end
  endtask
  task x(input [3:0] c, input [15:0] m, d, input [16:0] e=0, input [7:0] r=0, s=8'h04);
    u_cmd.op(c, m, d, r, s);
    if (c>6) get(e);
    else @(negedge REF_CLK);
  endtask
  initial begin
    repeat (3) @(posedge REF_CLK);
    NRST<=1;
    x(6,0,0); x(8,0,0,17'h10000);
    x(1,16'h20,16'h8000); x(2,16'hF00,1); x(4,16'h100,1); x(3,16'h8000,0); x(1,1,0);
    x(8,0,0,17'h18E20); x(7,16'h200,0,17'h10001);
    st(17'h18E20);
    $display("channel test done");
    @(posedge REF_CLK) NRST<=0;
    repeat (2) @(posedge REF_CLK);
    NRST<=1;
    @(negedge REF_CLK);
    st(17'h10000);
    $display("reset test done");
    x(5,0,16'hFE1D); st(17'h1FE1D);
    x(5,0,16'hFFFF,0,0,1); st(17'h1FE1D);
    x(8,0,0,17'h1FE1D);
    x(8,0,0,17'hFE1D,3); st(17'h0FE1D);
    get(17'hFE1D); get(17'h1FE1D); x(9,0,0,17'h13C3C);
    $display("slot test done");
    results;
  end
endmodule
bind rcsb_bank rcsb_props #(.S(SLOT_ADDR)) u_props (.*);
